/* chg_defines.svh */
// Purpose: offsets, field masks, reset values and bus constants of the charger register bank
// Assumes: one 20 MHz clock, byte-wide registers reached over the two-wire serial bus
// Notes: every number used by the design lives here as a macro, except the id byte, a parameter of chg_regbank
//
// Overview of operation
// - The bank answers only to 7-bit serial bus address 0100101, which the host must use.
// - Reading the event-flag register at offset 0x01 returns its contents and then clears it.
// - Event bit 5 is set whenever the 3-bit temperature zone code changes.
// - Event bit 4 is set whenever the charger-on flag changes in either direction.
// - Event bit 3 is set whenever the fast-charge-timer-expired flag changes.
// - Event bit 2 is set on both rising and falling changes of the overvoltage flag.
// - Event bit 1 is set whenever the power-good flag changes.
// - Event bit 0 is set whenever the end-of-charge flag changes.
// - Clear-on-read registers clear when read, read/write keep writes, read-only ignore them.
// - Each event mask bit passes (1) or blocks (0) the event flag at the same position.
// - Mode 000 off, 001 prequal, 010/011 slow CC/CV, 100/101 fast CC/CV, 110 top-off, 111 done.
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH

// bus address of this register map
`define CHG_BUS_ADDR 7'h25

// register offsets
`define CHG_OFF_ID 8'h00
`define CHG_OFF_EVT 8'h01
`define CHG_OFF_STA 8'h02
`define CHG_OFF_STB 8'h03
`define CHG_OFF_MASK 8'h04
`define CHG_OFF_TMR 8'h05
`define CHG_OFF_CTL 8'h06
`define CHG_OFF_CV 8'h07
`define CHG_OFF_CC 8'h08
`define CHG_OFF_TRM 8'h09
`define CHG_OFF_TEMP 8'h0a
`define CHG_OFF_CHARGER_FUNCTION_CFG 8'h0b

// power-on values
`define CHG_RST_EVT 8'h00
`define CHG_RST_MASK 8'h00
`define CHG_RST_TMR 8'h07
`define CHG_RST_CTL 8'h05
`define CHG_RST_CV 8'h29
`define CHG_RST_CC 8'h04
`define CHG_RST_TRM 8'h81
`define CHG_RST_TEMP 8'h8f
`define CHG_RST_CHARGER_FUNCTION_CFG 8'h68

// implemented bits of each writable register; reserved bits read zero
`define CHG_WM_MASK 8'h3f
`define CHG_WM_TMR 8'h3f
`define CHG_WM_CTL 8'h37
`define CHG_WM_CV 8'h3f
`define CHG_WM_CC 8'h0f
`define CHG_WM_TRM 8'h9f
`define CHG_WM_TEMP 8'h8f
`define CHG_WM_CHARGER_FUNCTION_CFG 8'hef

// event flag positions
`define CHG_EVT_TEMP 5
`define CHG_EVT_ON 4
`define CHG_EVT_TIMER 3
`define CHG_EVT_OVP 2
`define CHG_EVT_PGOOD 1
`define CHG_EVT_END 0
`define CHG_EVT_LEVELS 5

// value read back from an unmapped offset
`define CHG_UNMAPPED 8'h00

`endif

/* chg_pkg.sv */
// Purpose: types shared by the charger register bank files
// Assumes: constants come from chg_defines.svh
// Notes: structs carry the status inputs and the configuration outputs
package chg_pkg;

    // charger state code, fixed encoding
    typedef enum logic [2:0] {
        CHG_MODE_OFF = 3'h0,
        CHG_MODE_PREQUAL = 3'h1,
        CHG_MODE_SLOW_CC = 3'h2,
        CHG_MODE_SLOW_CV = 3'h3,
        CHG_MODE_FAST_CC = 3'h4,
        CHG_MODE_FAST_CV = 3'h5,
        CHG_MODE_TOP_OFF = 3'h6,
        CHG_MODE_DONE = 3'h7
    } chg_mode_e;

    // live charger conditions from the analog side
    typedef struct packed {
        logic thermistor_error;
        logic charger_on_flag;
        logic fast_timer_expired;
        logic overvoltage_flag;
        logic power_good_flag;
        logic charge_end_flag;
        chg_mode_e charger_state_code;
        logic [2:0] temp_zone_code;
    } chg_status_s;

    // configuration bytes as software left them
    typedef struct packed {
        logic [7:0] timer;
        logic [7:0] control;
        logic [7:0] voltage;
        logic [7:0] current;
        logic [7:0] termination;
        logic [7:0] temp_profile;
        logic [7:0] function_sel;
    } chg_config_s;

    // serial bus slave states
    typedef enum logic [2:0] {
        CHG_ST_IDLE = 3'h0,
        CHG_ST_ADDR = 3'h1,
        CHG_ST_ADDR_ACK = 3'h2,
        CHG_ST_WR = 3'h3,
        CHG_ST_WR_ACK = 3'h4,
        CHG_ST_RD = 3'h5,
        CHG_ST_RD_ACK = 3'h6
    } chg_bus_state_e;

endpackage : chg_pkg

/* chg_event_flags.sv */
// Purpose: change detection and sticky event flags of the charger
// Assumes: status levels are synchronous to clk_sys
// Notes: a set arriving with the read clear survives the clear
`timescale 1ns/1ps
`default_nettype none
`include "chg_defines.svh"

module chg_event_flags (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // live conditions
    input wire logic [`CHG_EVT_LEVELS-1:0] levels,
    input wire logic [2:0] temp_zone_code,
    // clear from a read of the flag register
    input wire logic read_clear,
    // sticky flags
    output logic [5:0] flags
);
    logic [`CHG_EVT_LEVELS-1:0] prev_levels;
    logic [2:0] prev_zone;
    logic primed;
    logic [5:0] change;

    // first cycle after reset only captures, so power-up values raise no event
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_levels <= '0;
            prev_zone <= 3'h0;
            primed <= 1'b0;
        end else begin
            prev_levels <= levels;
            prev_zone <= temp_zone_code;
            primed <= 1'b1;
        end
    end

    // any change of the zone code, not only single steps
    assign change[`CHG_EVT_TEMP] = primed && (temp_zone_code != prev_zone);

    // one toggle detector per status level; both directions count
    genvar i;
    generate
        for (i = 0; i < `CHG_EVT_LEVELS; i++) begin : g_edge
            assign change[i] = primed &&
                (levels[i] ^ prev_levels[i]);
        end
    endgenerate

    // set wins over the read clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flags <= 6'(`CHG_RST_EVT);
        end else begin
            flags <= (flags & ~{6{read_clear}}) | change;
        end
    end

endmodule : chg_event_flags
`default_nettype wire

/* chg_regbank.sv */
// Purpose: charger register bank with its own serial bus slave
// Assumes: scl and sda inputs already synchronous to clk_sys (20 MHz)
// Notes: first written byte sets the register pointer, which then auto-increments
`timescale 1ns/1ps
`default_nettype none
`include "chg_defines.svh"

module chg_regbank #(
    // identification byte; value is arbitrary
    parameter logic [7:0] CHARGER_ID_REG_VALUE = 8'h5a
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // charger side
    input wire chg_pkg::chg_status_s status,
    output chg_pkg::chg_config_s config_out,
    // interrupt, active low
    output logic irq_n
);
    import chg_pkg::*;

    chg_bus_state_e state;
    logic scl_q;
    logic sda_q;
    logic scl_p;
    logic sda_p;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] shift_in;
    logic [7:0] tx;
    logic [2:0] bit_cnt;
    logic byte_done;
    logic is_read;
    logic ptr_pending;
    logic host_nack;
    logic [7:0] ptr;
    logic [7:0] rd_mux;
    logic load_rd;
    logic do_write;
    logic [5:0] flags;
    logic [7:0] status_a;
    logic [7:0] status_b;
    logic [7:0] event_mask_reg;
    logic [7:0] charger_timer_cfg;
    logic [7:0] charger_control_cfg;
    logic [7:0] charge_voltage_cfg;
    logic [7:0] charge_current_cfg;
    logic [7:0] charge_termination_cfg;
    logic [7:0] temperature_profile_cfg;
    logic [7:0] charger_function_cfg;

    // one register stage on the pins plus a previous copy for edges
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            scl_p <= scl_q;
            sda_p <= sda_q;
        end
    end

    assign scl_rise = scl_q && !scl_p;
    assign scl_fall = !scl_q && scl_p;
    assign bus_start = scl_q && scl_p && sda_p && !sda_q;
    assign bus_stop = scl_q && scl_p && !sda_p && sda_q;

    // next byte to send is fetched at the ack falling edge
    assign load_rd = scl_fall && !bus_start && !bus_stop
        && ((state == CHG_ST_ADDR_ACK && is_read) || (state == CHG_ST_RD_ACK && !host_nack));
    // write of a data byte once its eighth bit is in
    assign do_write = scl_fall && state == CHG_ST_WR && byte_done && !ptr_pending;

    // read data selection; reserved bits are already zero in storage
    always_comb begin
        unique case (ptr)
            `CHG_OFF_ID: rd_mux = CHARGER_ID_REG_VALUE;
            `CHG_OFF_EVT: rd_mux = {2'b00, flags};
            `CHG_OFF_STA: rd_mux = status_a;
            `CHG_OFF_STB: rd_mux = status_b;
            `CHG_OFF_MASK: rd_mux = event_mask_reg;
            `CHG_OFF_TMR: rd_mux = charger_timer_cfg;
            `CHG_OFF_CTL: rd_mux = charger_control_cfg;
            `CHG_OFF_CV: rd_mux = charge_voltage_cfg;
            `CHG_OFF_CC: rd_mux = charge_current_cfg;
            `CHG_OFF_TRM: rd_mux = charge_termination_cfg;
            `CHG_OFF_TEMP: rd_mux = temperature_profile_cfg;
            `CHG_OFF_CHARGER_FUNCTION_CFG: rd_mux = charger_function_cfg;
            default: rd_mux = `CHG_UNMAPPED;
        endcase
    end

    // bus slave: bits sampled on scl rise, sda changed on scl fall
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= CHG_ST_IDLE;
            shift_in <= 8'h00;
            tx <= 8'h00;
            bit_cnt <= 3'h0;
            byte_done <= 1'b0;
            is_read <= 1'b0;
            ptr_pending <= 1'b0;
            host_nack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (bus_start) begin
            state <= CHG_ST_ADDR;
            bit_cnt <= 3'h0;
            byte_done <= 1'b0;
            sda_oe <= 1'b0;
        end else if (bus_stop) begin
            state <= CHG_ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            unique case (state)
                CHG_ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                CHG_ST_ADDR, CHG_ST_WR: begin
                    if (scl_rise) begin
                        shift_in <= {shift_in[6:0], sda_q};
                        bit_cnt <= bit_cnt + 3'h1;
                        byte_done <= (bit_cnt == 3'h7);
                    end else if (scl_fall && byte_done) begin
                        byte_done <= 1'b0;
                        if (state == CHG_ST_WR) begin
                            sda_oe <= 1'b1; // ack every data byte
                            state <= CHG_ST_WR_ACK;
                            ptr_pending <= 1'b0;
                        end else if (shift_in[7:1] == `CHG_BUS_ADDR) begin
                            sda_oe <= 1'b1;
                            is_read <= shift_in[0];
                            ptr_pending <= !shift_in[0];
                            state <= CHG_ST_ADDR_ACK;
                        end else begin
                            state <= CHG_ST_IDLE; // other address: stay off the bus
                        end
                    end
                end
                CHG_ST_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 3'h0;
                        state <= CHG_ST_WR;
                    end
                end
                CHG_ST_ADDR_ACK, CHG_ST_RD_ACK: begin
                    if (scl_rise && state == CHG_ST_RD_ACK) begin
                        host_nack <= sda_q;
                    end
                    if (load_rd) begin
                        tx <= rd_mux;
                        sda_oe <= !rd_mux[7];
                        bit_cnt <= 3'h0;
                        state <= CHG_ST_RD;
                    end else if (scl_fall) begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 3'h0;
                        state <= is_read ? CHG_ST_IDLE : CHG_ST_WR;
                    end
                end
                CHG_ST_RD: begin
                    if (scl_fall) begin
                        if (bit_cnt == 3'h7) begin
                            sda_oe <= 1'b0; // release for the host ack
                            host_nack <= 1'b0;
                            state <= CHG_ST_RD_ACK;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            sda_oe <= !tx[6];
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                    end
                end
                default: begin
                    state <= CHG_ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // open-drain data line only ever pulls low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // register pointer: set by the first written byte, stepped after each access
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ptr <= 8'h00;
        end else if (scl_fall && state == CHG_ST_WR && byte_done && ptr_pending) begin
            ptr <= shift_in;
        end else if (do_write || load_rd) begin
            ptr <= ptr + 8'h01;
        end
    end

    // writable registers; id, flags and status ignore writes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            event_mask_reg <= `CHG_RST_MASK;
            charger_timer_cfg <= `CHG_RST_TMR;
            charger_control_cfg <= `CHG_RST_CTL;
            charge_voltage_cfg <= `CHG_RST_CV;
            charge_current_cfg <= `CHG_RST_CC;
            charge_termination_cfg <= `CHG_RST_TRM;
            temperature_profile_cfg <= `CHG_RST_TEMP;
            charger_function_cfg <= `CHG_RST_CHARGER_FUNCTION_CFG;
        end else if (do_write) begin
            case (ptr)
                `CHG_OFF_MASK: event_mask_reg <= shift_in & `CHG_WM_MASK;
                `CHG_OFF_TMR: charger_timer_cfg <= shift_in & `CHG_WM_TMR;
                `CHG_OFF_CTL: charger_control_cfg <= shift_in & `CHG_WM_CTL;
                `CHG_OFF_CV: charge_voltage_cfg <= shift_in & `CHG_WM_CV;
                `CHG_OFF_CC: charge_current_cfg <= shift_in & `CHG_WM_CC;
                `CHG_OFF_TRM: charge_termination_cfg <= shift_in & `CHG_WM_TRM;
                `CHG_OFF_TEMP: temperature_profile_cfg <= shift_in & `CHG_WM_TEMP;
                `CHG_OFF_CHARGER_FUNCTION_CFG: charger_function_cfg <= shift_in & `CHG_WM_CHARGER_FUNCTION_CFG;
                default: begin
                end
            endcase
        end
    end

    // configuration outputs come from their own flops, one cycle behind storage
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            config_out <= {`CHG_RST_TMR, `CHG_RST_CTL, `CHG_RST_CV, `CHG_RST_CC,
                           `CHG_RST_TRM, `CHG_RST_TEMP, `CHG_RST_CHARGER_FUNCTION_CFG};
        end else begin
            config_out <= {charger_timer_cfg, charger_control_cfg, charge_voltage_cfg,
                           charge_current_cfg, charge_termination_cfg,
                           temperature_profile_cfg, charger_function_cfg};
        end
    end

    // status registers follow the live conditions every cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_a <= 8'h00;
            status_b <= 8'h00;
        end else begin
            status_a <= {2'b00, status.thermistor_error, status.charger_on_flag,
                         status.fast_timer_expired, status.overvoltage_flag,
                         status.power_good_flag, status.charge_end_flag};
            status_b <= {1'b0, status.charger_state_code, 1'b0, status.temp_zone_code};
        end
    end

    // flags; clear fires in the cycle the byte is copied to the shifter
    chg_event_flags u_flags (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .levels({status.charger_on_flag, status.fast_timer_expired, status.overvoltage_flag,
                 status.power_good_flag, status.charge_end_flag}),
        .temp_zone_code(status.temp_zone_code),
        .read_clear(load_rd && ptr == `CHG_OFF_EVT),
        .flags(flags)
    );

    // interrupt gated per bit by the mask; a flag set in the same cycle as the clear keeps it low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(|(flags & event_mask_reg[5:0]));
        end
    end

endmodule : chg_regbank
`default_nettype wire

/* chg_regbank_asserts.sv */
// Purpose: port-level checks on the charger register bank
// Assumes: host keeps bus clock phases of at least 4 clk_sys cycles
// Notes: flags and mask are internal, so irq_n is tied to its possible causes
`timescale 1ns/1ps
`default_nettype none
`include "chg_defines.svh"

module chg_regbank_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // charger side
    input wire chg_pkg::chg_status_s status,
    input wire chg_pkg::chg_config_s config_out,
    input wire logic irq_n
);
    import chg_pkg::*;

    localparam logic [55:0] POR_CFG = 56'h07_05_29_04_81_8f_68;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // cycles since status last moved; saturates so a quiet input never wraps back
    logic [3:0] quiet;
    chg_status_s prev_status;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            quiet <= 4'hf;
            prev_status <= '0;
        end else begin
            prev_status <= status;
            if (status != prev_status) quiet <= 4'h0;
            else if (quiet != 4'hf) quiet <= quiet + 4'h1;
        end
    end

    open_drain_a: assert property (sda_out == 1'b0)
        else $error("sda_out not held low");
    oe_moves_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("sda_oe moved while bus clock high");
    oe_holds_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
        else $error("sda_oe released too early");
    config_moves_a: assert property ($changed(config_out) |-> !scl_in)
        else $error("config changed outside a write slot");
    config_por_a: assert property ($rose(resetn) |-> config_out == POR_CFG)
        else $error("config not at power-on values");
    reserved_zero_a: assert property ((config_out.control & ~`CHG_WM_CTL) == 8'h00 &&
        (config_out.current & ~`CHG_WM_CC) == 8'h00 && (config_out.timer & ~`CHG_WM_TMR) == 8'h00)
        else $error("reserved config bits set");
    irq_release_a: assert property ($rose(irq_n) |-> !scl_in)
        else $error("irq released outside a bus slot");
    irq_cause_a: assert property ($fell(irq_n) |-> quiet < 4'h4 || !scl_in)
        else $error("irq raised without a cause");

    // main scenarios reached
    cover property ($fell(irq_n));
    cover property ($rose(sda_oe));
    cover property ($changed(config_out));
endmodule : chg_regbank_asserts

bind chg_regbank chg_regbank_asserts chk (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .status(status),
    .config_out(config_out), .irq_n(irq_n));
`default_nettype wire

/* chg_host_model.sv */
// Purpose: two-wire bus host that reads and writes the charger registers
// Assumes: signals change at the falling clk_sys edge, 4 cycles per third of a bit slot
// Notes: host only pulls sda low; the wire level comes from the bench
`timescale 1ns/1ps
`default_nettype none

module chg_host_model (
    // clock
    input wire logic clk_sys,
    // bus wire as seen by all parties
    input wire logic sda_wire,
    // host drive
    output logic scl_out,
    output logic sda_pull
);
    localparam int HALF = 4;
    localparam logic [6:0] ADDR = 7'h25;

    // bus idle at time zero
    initial begin
        scl_out = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_clk

    // one bit slot: data set while scl low, sampled at the end of the high phase
    task automatic slot(input logic b, output logic seen);
        sda_pull = ~b;
        wait_clk(HALF);
        scl_out = 1'b1;
        wait_clk(HALF);
        seen = sda_wire;
        scl_out = 1'b0;
        wait_clk(HALF);
    endtask : slot

    task automatic start_c();
        sda_pull = 1'b0;
        wait_clk(HALF);
        scl_out = 1'b1;
        wait_clk(HALF);
        sda_pull = 1'b1;
        wait_clk(HALF);
        scl_out = 1'b0;
        wait_clk(HALF);
    endtask : start_c

    task automatic stop_c();
        sda_pull = 1'b1;
        wait_clk(HALF);
        scl_out = 1'b1;
        wait_clk(HALF);
        sda_pull = 1'b0;
        wait_clk(HALF);
    endtask : stop_c

    // eight data slots msb first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
        output logic ack_seen);
        for (int i = 7; i >= 0; i--) slot(tx[i], rx[i]);
        slot(ack_in, ack_seen);
    endtask : xbyte

    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start_c();
        xbyte({ADDR, 1'b0}, 1'b1, rx, a0);
        xbyte(ptr, 1'b1, rx, a1);
        xbyte(d, 1'b1, rx, a2);
        stop_c();
        ok = !(a0 | a1 | a2);
    endtask : wr_reg

    // pointer write, repeated start, one byte read closed by a nack
    task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, nk;
        start_c();
        xbyte({ADDR, 1'b0}, 1'b1, rx, a0);
        xbyte(ptr, 1'b1, rx, a1);
        start_c();
        xbyte({ADDR, 1'b1}, 1'b1, rx, a2);
        xbyte(8'hff, 1'b1, d, nk);
        stop_c();
        ok = !(a0 | a1 | a2);
    endtask : rd_reg
endmodule : chg_host_model
`default_nettype wire

/* chg_regbank_tb_top.sv */
// Purpose: self-checking bench for the charger register bank
// Assumes: 20 MHz clk_sys, inputs change at the falling edge
// Notes: expected values come from the register table, not from the design
`timescale 1ns/1ps
`default_nettype none
`include "chg_defines.svh"

module chg_regbank_tb_top;
    import chg_pkg::*;

    localparam logic [7:0] ID_VALUE = 8'h3c; // arbitrary identification byte
    localparam int LIMIT = 60000;

    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic scl;
    logic host_pull;
    logic sda_out;
    logic sda_oe;
    logic irq_n;
    logic sda_wire;
    chg_status_s status_in = '0;
    chg_config_s config_out;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] rd;
    logic ok;
    // writable registers from offset 0x04 upward
    logic [7:0] por [8] = '{8'h00, 8'h07, 8'h05, 8'h29, 8'h04, 8'h81, 8'h8f, 8'h68};
    logic [7:0] wmask [8] = '{`CHG_WM_MASK, `CHG_WM_TMR, `CHG_WM_CTL, `CHG_WM_CV, `CHG_WM_CC,
        `CHG_WM_TRM, `CHG_WM_TEMP, `CHG_WM_CHARGER_FUNCTION_CFG};

    // open-drain wire with pull-up: low while either side pulls
    assign sda_wire = ~(host_pull | sda_oe);

    chg_regbank #(.CHARGER_ID_REG_VALUE(ID_VALUE)) uut (.clk_sys(clk_sys), .resetn(resetn),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .status(status_in), .config_out(config_out), .irq_n(irq_n));
    chg_host_model host (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl_out(scl),
        .sda_pull(host_pull));

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp1

    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
        host.rd_reg(ptr, rd, ok);
        cmp1(ok, 1'b1);
        cmp8(rd, exp);
    endtask : rd_chk

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        host.wr_reg(ptr, d, ok);
        cmp1(ok, 1'b1);
    endtask : wr

    // toggle the live condition behind one event bit
    task automatic flip(input int b);
        if (b == 5) status_in.temp_zone_code = status_in.temp_zone_code ^ 3'h5;
        else status_in[6+b] = ~status_in[6+b];
    endtask : flip

    task automatic t_reset();
        cmp1(irq_n, 1'b1);
        for (int i = 1; i < 8; i++) cmp8(config_out[8*(7-i) +: 8], por[i]);
        rd_chk(8'h00, ID_VALUE);
        for (int i = 1; i < 4; i++) rd_chk(8'(i), 8'h00);
        for (int i = 0; i < 8; i++) rd_chk(8'h04 + 8'(i), por[i]);
    endtask : t_reset

    task automatic t_rw();
        logic [7:0] rx;
        logic a;
        // one burst fills every writable register, pointer steps by one
        host.start_c();
        host.xbyte(8'h4a, 1'b1, rx, a);
        cmp1(a, 1'b0);
        host.xbyte(8'h04, 1'b1, rx, a);
        for (int i = 0; i < 8; i++) host.xbyte(8'hff, 1'b1, rx, a);
        host.stop_c();
        for (int i = 0; i < 8; i++) rd_chk(8'h04 + 8'(i), wmask[i]);
        for (int i = 1; i < 8; i++) cmp8(config_out[8*(7-i) +: 8], wmask[i]);
        // read-only, clear-on-read and unmapped places ignore writes
        wr(8'h00, 8'h00);
        wr(8'h01, 8'hff);
        wr(8'h02, 8'hff);
        wr(8'h30, 8'hff);
        rd_chk(8'h00, ID_VALUE);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h30, 8'h00);
    endtask : t_rw

    task automatic t_addr();
        logic [7:0] rx;
        logic a;
        logic [6:0] bad [3] = '{7'h24, 7'h26, 7'h65};
        for (int i = 0; i < 3; i++) begin
            host.start_c();
            host.xbyte({bad[i], 1'b0}, 1'b1, rx, a);
            cmp1(a, 1'b1);
            host.xbyte(8'h04, 1'b1, rx, a);
            host.xbyte(8'h00, 1'b1, rx, a);
            host.stop_c();
        end
        rd_chk(8'h04, 8'h3f);
    endtask : t_addr

    task automatic t_events();
        for (int b = 0; b < 6; b++) begin
            wr(8'h04, 8'h00);
            flip(b);
            repeat (4) @(negedge clk_sys);
            cmp1(irq_n, 1'b1);
            rd_chk(8'h01, 8'h01 << b);
            rd_chk(8'h01, 8'h00);
            wr(8'h04, 8'h01 << b);
            flip(b);
            repeat (4) @(negedge clk_sys);
            cmp1(irq_n, 1'b0);
            rd_chk(8'h01, 8'h01 << b);
            cmp1(irq_n, 1'b1);
        end
    endtask : t_events

    task automatic t_status();
        for (int m = 0; m < 8; m++) begin
            status_in.charger_state_code = chg_mode_e'(m);
            status_in.temp_zone_code = 3'(7 - m);
            status_in.thermistor_error = m[0];
            repeat (4) @(negedge clk_sys);
            rd_chk(8'h03, {1'b0, 3'(m), 1'b0, 3'(7 - m)});
            rd_chk(8'h02, {2'b00, m[0], 5'h00});
        end
        rd_chk(8'h01, 8'h20);
    endtask : t_status

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_reset();
        t_rw();
        t_addr();
        t_events();
        t_status();
        print_verdict();
    end
endmodule : chg_regbank_tb_top
`default_nettype wire
